// >>> bench/pcie_dma_control_regs_test.sv
// Self-checking testbench of the DMA control block.
`timescale 1ns/1ps
`include "pdc_regs.vh"
module pcie_dma_control_regs_test;
  reg ref_clk_i, sys_rst_i, clk_en_i, reg_wr_i, reg_rd_i, reg_bar_i, push_button_i;
  reg [15:0] reg_addr_i;
  reg [31:0] reg_wdata_i;
  reg [3:0] dip_switch_i;
  wire [31:0] reg_rdata_o, src_data_o, dst_data_o, host_base_o, xfer_length_o, rx_n, bad_n;
  wire reg_rvalid_o, src_valid_o, src_ready_o, dst_valid_o, dst_ready_i, xfer_busy_o;
  wire host_irq_o;
  wire [3:0] dir_sel_o;
  wire [7:0] led_o;
  logic [31:0] exp_q[$]; // Expected read answers, oldest first.
  string name_q[$]; // Names of the pending reads.
  int n_errors = 0, num_checks = 0, n_busy = 0, n_irq = 0, cyc = 0, k;
  reg [31:0] v;
  pdc_dma_ctrl uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_bar_i(reg_bar_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .src_valid_i(src_valid_o), .src_data_i(src_data_o), .src_ready_o(src_ready_o),
    .dst_valid_o(dst_valid_o), .dst_data_o(dst_data_o), .dst_ready_i(dst_ready_i),
    .dir_sel_o(dir_sel_o), .host_base_o(host_base_o), .xfer_length_o(xfer_length_o),
    .xfer_busy_o(xfer_busy_o), .led_o(led_o), .dip_switch_i(dip_switch_i),
    .push_button_i(push_button_i), .host_irq_o(host_irq_o));
  pdc_mem_model u_mem (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .src_ready_i(src_ready_o),
    .src_valid_o(src_valid_o), .src_data_o(src_data_o), .dst_valid_i(dst_valid_o),
    .dst_data_i(dst_data_o), .dst_ready_o(dst_ready_i), .rx_count_o(rx_n), .bad_count_o(bad_n));
  // The 40 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One write strobe, then a released cycle, so strobes never merge.
  task wr(input b, input [15:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_bar_i <= b;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // A read notes its expected answer for the watcher below.
  task rd(input b, input [15:0] a, input [31:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_bar_i <= b;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  // Watcher: counts busy cycles and interrupts, matches read answers, cuts a hang short.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (xfer_busy_o === 1'b1) n_busy++;
    if (host_irq_o === 1'b1) n_irq++;
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) check("read_extra", 32'h1, 32'h0);
      else check(name_q.pop_front(), reg_rdata_o, exp_q.pop_front());
    end
    if (cyc == 100000) begin
      n_errors++;
      complete_run();
    end
  end
  // One press held for two cycles, then quiet long enough for any pulse.
  task press;
    @(posedge ref_clk_i);
    push_button_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    push_button_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  // A whole transfer: length and base first, then the direction code starts it.
  task xfer(input [31:0] code, input [31:0] len, input [3:0] sel);
    int rx0;
    rx0 = rx_n;
    wr(1'b1, `PDC_OFF_XFER_LENGTH, len);
    wr(1'b1, `PDC_OFF_HOST_BASE, v);
    wr(1'b1, `PDC_OFF_XFER_DIR, code);
    n_busy = 0;
    #1;
    check("busy", xfer_busy_o, 32'h1);
    check("dir_sel", dir_sel_o, sel);
    check("host_base", host_base_o, v);
    check("length", xfer_length_o, len);
    rd(1'b1, `PDC_OFF_DONE_FLAG, 32'h0, "done_running");
    for (k = 0; k < 60000 && xfer_busy_o !== 1'b0; k++) @(posedge ref_clk_i);
    #1;
    check("words", rx_n - rx0, len >> 2);
    check("order", bad_n, 32'h0);
    rd(1'b1, `PDC_OFF_DONE_FLAG, 32'h1, "done");
    rd(1'b1, `PDC_OFF_CYCLE_COUNT, n_busy, "cycles");
  endtask
  initial begin
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_bar_i = 1'b0;
    reg_addr_i = 16'h0;
    reg_wdata_i = 32'h0;
    push_button_i = 1'b0;
    v = $urandom(69);
    v = $urandom;
    dip_switch_i = v[3:0];
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(1'b1, `PDC_OFF_DONE_FLAG, 32'h0, "done_reset");
    rd(1'b1, 16'h4000, 32'h0, "unmapped");
    wr(1'b1, `PDC_OFF_SCRATCHPAD, v);
    wr(1'b1, `PDC_OFF_CYCLE_COUNT, v);
    // A write while the clock enable is low must leave the scratchpad as it was.
    clk_en_i <= 1'b0;
    wr(1'b1, `PDC_OFF_SCRATCHPAD, ~v);
    clk_en_i <= 1'b1;
    rd(1'b1, `PDC_OFF_SCRATCHPAD, v, "scratchpad");
    rd(1'b1, `PDC_OFF_CYCLE_COUNT, 32'h0, "count_ro");
    wr(1'b0, `PDC_OFF_LED_DRIVE, ~v);
    #1;
    check("led", led_o, {24'h0, ~v[7:0]});
    rd(1'b0, `PDC_OFF_DIP_SWITCH, {20'h0, v[3:0], 8'h0}, "dip");
    // Interrupts: lost while disabled, one per press when enabled, none after clear.
    press;
    wr(1'b0, `PDC_OFF_IRQ_CTRL, 32'h1);
    press;
    check("irq_on", n_irq, 32'h1);
    rd(1'b0, `PDC_OFF_IRQ_CTRL, 32'h3, "irq_ctrl");
    wr(1'b0, `PDC_OFF_IRQ_CTRL, 32'h3);
    press;
    check("irq_off", n_irq, 32'h1);
    rd(1'b0, `PDC_OFF_IRQ_CTRL, 32'h0, "irq_clear");
    xfer(`PDC_DIR_HOST_TO_DDR, `PDC_HOST_LEN_MIN, 4'h1);
    xfer(`PDC_DIR_DDR_TO_HOST, `PDC_HOST_LEN_MIN, 4'h2);
    xfer(`PDC_DIR_SRAM_TO_DDR, `PDC_SRAM_LEN_MIN, 4'h4);
    xfer(`PDC_DIR_DDR_TO_SRAM, `PDC_SRAM_LEN_MAX, 4'h8);
    // Unknown code and an odd host length must both leave the engine idle.
    wr(1'b1, `PDC_OFF_XFER_DIR, 32'h11AA5555);
    #1;
    check("bad_code", xfer_busy_o, 32'h0);
    wr(1'b1, `PDC_OFF_XFER_LENGTH, `PDC_HOST_LEN_MIN + 32'h4);
    wr(1'b1, `PDC_OFF_XFER_DIR, `PDC_DIR_HOST_TO_DDR);
    #1;
    check("bad_length", xfer_busy_o, 32'h0);
    rd(1'b1, `PDC_OFF_DONE_FLAG, 32'h1, "done_kept");
    repeat (4) @(posedge ref_clk_i);
    check("reads_left", exp_q.size(), 32'h0);
    complete_run();
  end
endmodule

// >>> bench/pdc_dma_ctrl_monitor.sv
// Concurrent checks on the ports of the DMA control block.
`timescale 1ns/1ps
`include "pdc_regs.vh"
module pdc_dma_ctrl_monitor (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire reg_bar_i,
  input wire [15:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire src_ready_o,
  input wire dst_valid_o,
  input wire [31:0] dst_data_o,
  input wire dst_ready_i,
  input wire [3:0] dir_sel_o,
  input wire [31:0] xfer_length_o,
  input wire xfer_busy_o,
  input wire [7:0] led_o,
  input wire push_button_i,
  input wire host_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Write strobes that the block takes, one per window.
  wire wr1 = clk_en_i && reg_wr_i && reg_bar_i;
  wire wr0 = clk_en_i && reg_wr_i && !reg_bar_i;
  // A direction write while idle is the only thing that may start the engine.
  wire dwr = wr1 && reg_addr_i == `PDC_OFF_XFER_DIR && !xfer_busy_o;
  read_answer_a: assert property (clk_en_i && reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  read_quiet_a: assert property (clk_en_i && !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0)
    else $error("read answer without a read");
  led_write_a: assert property (wr0 && reg_addr_i == `PDC_OFF_LED_DRIVE |=>
    led_o == $past(reg_wdata_i[7:0])) else $error("leds do not follow write");
  start_host_a: assert property (dwr && reg_wdata_i == `PDC_DIR_HOST_TO_DDR &&
    xfer_length_o == `PDC_HOST_LEN_MIN |=> xfer_busy_o && dir_sel_o == 4'h1)
    else $error("valid start not taken");
  bad_code_a: assert property (dwr && reg_wdata_i[31:16] != 16'h11AA |=> !xfer_busy_o)
    else $error("unknown code started a transfer");
  bad_length_a: assert property (dwr && reg_wdata_i[15:0] == 16'h1111 &&
    xfer_length_o[15:0] != 16'h0 |=> !xfer_busy_o) else $error("odd length started");
  idle_ready_a: assert property (!xfer_busy_o |-> !src_ready_o)
    else $error("source taken while idle");
  dst_hold_a: assert property (dst_valid_o && !dst_ready_i |=> dst_valid_o &&
    $stable(dst_data_o)) else $error("stalled word changed");
  irq_cause_a: assert property (host_irq_o |-> $past(push_button_i) &&
    !$past(push_button_i, 2)) else $error("interrupt without a press");
  irq_pulse_a: assert property (host_irq_o |=> !host_irq_o)
    else $error("interrupt longer than one cycle");
  clear_quiet_a: assert property (wr0 && reg_addr_i == `PDC_OFF_IRQ_CTRL && reg_wdata_i[1] &&
    !(push_button_i && !$past(push_button_i)) |=> !host_irq_o [*4])
    else $error("interrupt after clear");
endmodule
bind pdc_dma_ctrl pdc_dma_ctrl_monitor u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_bar_i(reg_bar_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .src_ready_o(src_ready_o), .dst_valid_o(dst_valid_o),
  .dst_data_o(dst_data_o), .dst_ready_i(dst_ready_i), .dir_sel_o(dir_sel_o),
  .xfer_length_o(xfer_length_o), .xfer_busy_o(xfer_busy_o), .led_o(led_o),
  .push_button_i(push_button_i), .host_irq_o(host_irq_o));

// >>> bench/pdc_mem_model.sv
// Memory model that feeds the source stream and drains the sink stream.
`timescale 1ns/1ps
module pdc_mem_model (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire src_ready_i,
  output reg src_valid_o,
  output wire [31:0] src_data_o,
  input wire dst_valid_i,
  input wire [31:0] dst_data_i,
  output reg dst_ready_o,
  output reg [31:0] rx_count_o,
  output reg [31:0] bad_count_o
);
  reg [31:0] word_ff; // Next word offered by the source.
  reg [31:0] want_ff; // Next word the sink expects, so loss or reorder shows.
  // An idle source shows the inverse word, so a stale value is never read as fresh.
  assign src_data_o = src_valid_o ? word_ff : ~word_ff;
  // Both sides stall at random, one cycle in four, to exercise the FIFO.
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_valid_o <= 1'b0;
      dst_ready_o <= 1'b0;
      word_ff <= 32'h0;
      want_ff <= 32'h0;
      rx_count_o <= 32'h0;
      bad_count_o <= 32'h0;
    end else begin
      if (src_valid_o && src_ready_i) word_ff <= word_ff + 32'h1;
      // A word on offer is held until it is taken.
      if (!src_valid_o || src_ready_i) src_valid_o <= ($urandom % 4) != 0;
      dst_ready_o <= ($urandom % 4) != 0;
      // Each beat carries exactly one word of the sequence.
      if (dst_valid_i && dst_ready_o) begin
        rx_count_o <= rx_count_o + 32'h1;
        if (dst_data_i !== want_ff) bad_count_o <= bad_count_o + 32'h1;
        want_ff <= want_ff + 32'h1;
      end
    end
  end
endmodule

// >>> verilog/pdc_dma_ctrl.v
// DMA control and status registers with the board LED, switch and button logic.
`timescale 1ns/1ps
`include "pdc_regs.vh"
module pdc_dma_ctrl (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire reg_bar_i,
  input wire [15:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  output wire [31:0] reg_rdata_o,
  output wire reg_rvalid_o,
  input wire src_valid_i,
  input wire [31:0] src_data_i,
  output wire src_ready_o,
  output wire dst_valid_o,
  output wire [31:0] dst_data_o,
  input wire dst_ready_i,
  output wire [3:0] dir_sel_o,
  output wire [31:0] host_base_o,
  output wire [31:0] xfer_length_o,
  output wire xfer_busy_o,
  output wire [7:0] led_o,
  input wire [3:0] dip_switch_i,
  input wire push_button_i,
  output wire host_irq_o
);

  // One-hot engine states.
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  // Host-visible registers.
  reg [31:0] scratchpad_ff; // Plain read/write word.
  reg [7:0] led_ff; // Drives the board LEDs directly.
  reg [31:0] length_ff; // Transfer length in bytes.
  reg [31:0] dir_code_ff; // Last direction code written.
  reg [31:0] base_ff; // Host buffer base address.
  reg [31:0] cycles_ff; // Clock cycles of the current or last transfer.
  reg done_ff; // High once the last transfer finished.
  reg irq_en_ff; // Interrupt enable.
  reg irq_pend_ff; // A button interrupt has been sent and not cleared.
  reg irq_ff; // One-cycle interrupt request towards the host.
  reg btn_prev_ff; // Previous button level for edge detection.

  // Engine state.
  reg [1:0] state_ff;
  reg [3:0] dir_sel_ff; // One-hot path select seen by the memory side.
  reg [31:0] total_ff; // Words to move.
  reg [31:0] in_cnt_ff; // Words taken from the source.
  reg [31:0] out_cnt_ff; // Words delivered to the sink.
  reg dst_valid_ff; // Output stage holding one word.
  reg [31:0] dst_data_ff;

  // Read answer stage.
  reg [31:0] rdata_ff;
  reg rvalid_ff;

  // FIFO wiring.
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire fifo_in_ready;

  // Maps a direction code to its one-hot path select; zero for unknown codes.
  function [3:0] dir_decode;
    input [31:0] code;
    begin
      dir_decode = 4'h0;
      case (code)
        `PDC_DIR_HOST_TO_DDR: dir_decode[`PDC_SEL_HOST_TO_DDR] = 1'b1;
        `PDC_DIR_DDR_TO_HOST: dir_decode[`PDC_SEL_DDR_TO_HOST] = 1'b1;
        `PDC_DIR_SRAM_TO_DDR: dir_decode[`PDC_SEL_SRAM_TO_DDR] = 1'b1;
        `PDC_DIR_DDR_TO_SRAM: dir_decode[`PDC_SEL_DDR_TO_SRAM] = 1'b1;
        default: dir_decode = 4'h0;
      endcase
    end
  endfunction

  // Checks the length against the limits of the selected path.
  function len_ok;
    input [3:0] sel;
    input [31:0] len;
    begin
      if (sel[`PDC_SEL_HOST_TO_DDR] || sel[`PDC_SEL_DDR_TO_HOST]) begin
        len_ok = (len >= `PDC_HOST_LEN_MIN) && (len <= `PDC_HOST_LEN_MAX) &&
                 ((len & `PDC_HOST_LEN_STEP_MASK) == 32'h0000_0000);
      end else begin
        len_ok = (len >= `PDC_SRAM_LEN_MIN) && (len <= `PDC_SRAM_LEN_MAX);
      end
    end
  endfunction

  // Address match helper for one window and offset.
  function hit;
    input bar;
    input [15:0] addr;
    input want_bar;
    input [15:0] want_off;
    begin
      hit = (bar == want_bar) && (addr == want_off);
    end
  endfunction

  // Start decode: a direction write with a known code and a legal length, while idle.
  wire dir_wr = reg_wr_i && hit(reg_bar_i, reg_addr_i, `PDC_BAR_DMA, `PDC_OFF_XFER_DIR);
  wire [3:0] new_sel = dir_decode(reg_wdata_i);
  wire start = dir_wr && (new_sel != 4'h0) && len_ok(new_sel, length_ff) &&
               (state_ff == ST_IDLE);
  wire [31:0] new_total = length_ff >> `PDC_BEAT_SHIFT;

  // Beat handshakes.
  wire src_take = src_valid_i & fifo_in_ready;
  wire out_load = fifo_out_valid & (~dst_valid_ff | dst_ready_i);
  wire dst_take = dst_valid_ff & dst_ready_i;
  wire last_beat = dst_take && (out_cnt_ff + 32'h0000_0001 == total_ff);

  // Next-state values, also used to give the FIFO a look-ahead fill enable.
  reg [1:0] nxt_state;
  reg [31:0] nxt_in_cnt;
  reg [31:0] nxt_total;
  reg nxt_fill_en;

  // Engine sequencing: idle until a valid start, run until the last word leaves.
  always @* begin
    nxt_state = state_ff;
    nxt_in_cnt = in_cnt_ff;
    nxt_total = total_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_RUN;
          nxt_in_cnt = 32'h0000_0000;
          nxt_total = new_total;
        end
      end
      ST_RUN: begin
        if (src_take) begin
          nxt_in_cnt = in_cnt_ff + 32'h0000_0001;
        end
        if (last_beat) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_fill_en = (nxt_state == ST_RUN) && (nxt_in_cnt < nxt_total);
  end

  // The FIFO decouples the source from the sink; a stalled sink stops the source.
  pdc_fifo #(
    .WIDTH(`PDC_DATA_W),
    .DEPTH(`PDC_FIFO_DEPTH),
    .AW(`PDC_FIFO_AW)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .fill_en_i(nxt_fill_en),
    .in_valid_i(src_valid_i),
    .in_data_i(src_data_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(out_load)
  );

  // Engine registers, counters and the completion flag.
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_IDLE;
      dir_sel_ff <= 4'h0;
      total_ff <= `PDC_RST_WORD;
      in_cnt_ff <= `PDC_RST_WORD;
      out_cnt_ff <= `PDC_RST_WORD;
      cycles_ff <= `PDC_RST_WORD;
      done_ff <= 1'b0;
      dst_valid_ff <= 1'b0;
      dst_data_ff <= `PDC_RST_WORD;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      in_cnt_ff <= nxt_in_cnt;
      total_ff <= nxt_total;
      if (start) begin
        // A new transfer clears the flag and counter before running.
        dir_sel_ff <= new_sel;
        done_ff <= 1'b0;
        cycles_ff <= `PDC_RST_WORD;
        out_cnt_ff <= `PDC_RST_WORD;
      end else if (state_ff == ST_RUN) begin
        cycles_ff <= cycles_ff + 32'h0000_0001;
        if (dst_take) begin
          out_cnt_ff <= out_cnt_ff + 32'h0000_0001;
        end
        if (last_beat) begin
          done_ff <= 1'b1;
        end
      end
      // Output stage: one word per beat, never more than one in flight.
      if (out_load) begin
        dst_valid_ff <= 1'b1;
        dst_data_ff <= fifo_out_data;
      end else if (dst_take) begin
        dst_valid_ff <= 1'b0;
      end
    end
  end

  // Software-written registers. Writes to unmapped offsets are dropped.
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scratchpad_ff <= `PDC_RST_WORD;
      led_ff <= `PDC_RST_LED;
      length_ff <= `PDC_RST_WORD;
      dir_code_ff <= `PDC_RST_WORD;
      base_ff <= `PDC_RST_WORD;
    end else if (clk_en_i && reg_wr_i) begin
      if (hit(reg_bar_i, reg_addr_i, `PDC_BAR_DMA, `PDC_OFF_SCRATCHPAD)) begin
        scratchpad_ff <= reg_wdata_i;
      end
      if (hit(reg_bar_i, reg_addr_i, `PDC_BAR_CTRL, `PDC_OFF_LED_DRIVE)) begin
        led_ff <= reg_wdata_i[`PDC_LED_MSB:0];
      end
      if (hit(reg_bar_i, reg_addr_i, `PDC_BAR_DMA, `PDC_OFF_XFER_LENGTH)) begin
        // The host is expected to set this before a start; it is sampled at start.
        length_ff <= reg_wdata_i;
      end
      if (hit(reg_bar_i, reg_addr_i, `PDC_BAR_DMA, `PDC_OFF_HOST_BASE)) begin
        base_ff <= reg_wdata_i;
      end
      if (dir_wr) begin
        // The code is stored even when it starts nothing, so software can read it back.
        dir_code_ff <= reg_wdata_i;
      end
    end
  end

  // Button interrupt: a rising edge while enabled sends one pulse and marks it pending.
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_en_ff <= 1'b0;
      irq_pend_ff <= 1'b0;
      irq_ff <= 1'b0;
      btn_prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      btn_prev_ff <= push_button_i;
      irq_ff <= 1'b0;
      if (reg_wr_i && hit(reg_bar_i, reg_addr_i, `PDC_BAR_CTRL, `PDC_OFF_IRQ_CTRL) &&
          reg_wdata_i[`PDC_IRQ_CLR_BIT]) begin
        // Clear-and-disable drops the pending mark and blocks later presses.
        irq_en_ff <= 1'b0;
        irq_pend_ff <= 1'b0;
      end else if (reg_wr_i && hit(reg_bar_i, reg_addr_i, `PDC_BAR_CTRL, `PDC_OFF_IRQ_CTRL) &&
                   reg_wdata_i[`PDC_IRQ_EN_BIT]) begin
        irq_en_ff <= 1'b1;
      end
      // A press taken while still enabled beats a clear in the same cycle, so it is never lost.
      if (irq_en_ff && push_button_i && !btn_prev_ff) begin
        irq_ff <= 1'b1;
        irq_pend_ff <= 1'b1;
      end
    end
  end

  // Read path: data answers one cycle after the read strobe; unmapped offsets read zero.
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= `PDC_RST_WORD;
      rvalid_ff <= 1'b0;
    end else if (clk_en_i) begin
      rvalid_ff <= reg_rd_i;
      rdata_ff <= `PDC_RST_WORD;
      if (reg_rd_i) begin
        if (reg_bar_i == `PDC_BAR_CTRL) begin
          case (reg_addr_i)
            `PDC_OFF_DIP_SWITCH: rdata_ff[`PDC_DIP_MSB:`PDC_DIP_LSB] <= dip_switch_i;
            `PDC_OFF_LED_DRIVE: rdata_ff[`PDC_LED_MSB:0] <= led_ff;
            `PDC_OFF_IRQ_CTRL: begin
              rdata_ff[`PDC_IRQ_EN_BIT] <= irq_en_ff;
              rdata_ff[`PDC_IRQ_PEND_BIT] <= irq_pend_ff;
            end
            default: rdata_ff <= `PDC_RST_WORD;
          endcase
        end else begin
          case (reg_addr_i)
            `PDC_OFF_SCRATCHPAD: rdata_ff <= scratchpad_ff;
            `PDC_OFF_XFER_LENGTH: rdata_ff <= length_ff;
            `PDC_OFF_XFER_DIR: rdata_ff <= dir_code_ff;
            `PDC_OFF_CYCLE_COUNT: rdata_ff <= cycles_ff;
            `PDC_OFF_DONE_FLAG: rdata_ff <= {31'h0000_0000, done_ff};
            `PDC_OFF_HOST_BASE: rdata_ff <= base_ff;
            default: rdata_ff <= `PDC_RST_WORD;
          endcase
        end
      end
    end
  end

  // All outputs come straight from flops.
  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign src_ready_o = fifo_in_ready;
  assign dst_valid_o = dst_valid_ff;
  assign dst_data_o = dst_data_ff;
  assign dir_sel_o = dir_sel_ff;
  assign host_base_o = base_ff;
  assign xfer_length_o = length_ff;
  assign xfer_busy_o = state_ff[1];
  assign led_o = led_ff;
  assign host_irq_o = irq_ff;

endmodule

// >>> verilog/pdc_fifo.v
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module pdc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire fill_en_i,
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);

  // Storage words, write and read indices, and fill level.
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  // Ready is registered so the source sees a flop; it looks one cycle ahead.
  reg ready_ff;

  wire push = in_valid_i & ready_ff;
  wire pop = out_valid_o & out_ready_i;
  wire [AW:0] nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready_o = ready_ff;
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o = mem_ff[rd_ptr_ff];

  // Pointer and level bookkeeping; ready drops as soon as the next level is full.
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      ready_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      ready_ff <= fill_en_i & (nxt_count < DEPTH);
    end
  end

  // Data words need no reset; only valid entries are ever read.
  always @(posedge ref_clk_i) begin
    if (clk_en_i && push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

endmodule

// >>> verilog/pdc_regs.vh
// Register map, direction codes, length limits and field positions of the DMA control block.
`ifndef PDC_REGS_VH
`define PDC_REGS_VH

// Window selectors of the two memory windows.
`define PDC_BAR_CTRL 1'b0
`define PDC_BAR_DMA 1'b1

// Offsets in the control window.
`define PDC_OFF_DIP_SWITCH 16'h0090
`define PDC_OFF_LED_DRIVE 16'h00A0
`define PDC_OFF_IRQ_CTRL 16'h00B0

// Offsets in the DMA window.
`define PDC_OFF_SCRATCHPAD 16'h0000
`define PDC_OFF_XFER_LENGTH 16'h8008
`define PDC_OFF_XFER_DIR 16'h800C
`define PDC_OFF_CYCLE_COUNT 16'h8014
`define PDC_OFF_DONE_FLAG 16'h8018
`define PDC_OFF_HOST_BASE 16'h8028

// Direction codes.
`define PDC_DIR_HOST_TO_DDR 32'h11AA1111
`define PDC_DIR_DDR_TO_HOST 32'h11AA2222
`define PDC_DIR_SRAM_TO_DDR 32'h11AA3333
`define PDC_DIR_DDR_TO_SRAM 32'h11AA4444

// One-hot direction select bits.
`define PDC_SEL_HOST_TO_DDR 0
`define PDC_SEL_DDR_TO_HOST 1
`define PDC_SEL_SRAM_TO_DDR 2
`define PDC_SEL_DDR_TO_SRAM 3

// Length limits in bytes, host paths move whole 64 KB descriptors.
`define PDC_HOST_LEN_MIN 32'h0001_0000
`define PDC_HOST_LEN_MAX 32'h0010_0000
`define PDC_HOST_LEN_STEP_MASK 32'h0000_FFFF
`define PDC_SRAM_LEN_MIN 32'h0000_4000
`define PDC_SRAM_LEN_MAX 32'h0000_8000

// Every beat carries one 32-bit word, so length in words is bytes shifted by two.
`define PDC_BEAT_SHIFT 2
`define PDC_DATA_W 32
`define PDC_FIFO_DEPTH 8
`define PDC_FIFO_AW 3

// Field positions.
`define PDC_DIP_LSB 8
`define PDC_DIP_MSB 11
`define PDC_LED_MSB 7
`define PDC_IRQ_EN_BIT 0
`define PDC_IRQ_CLR_BIT 1
`define PDC_IRQ_PEND_BIT 1

// Reset values.
`define PDC_RST_WORD 32'h0000_0000
`define PDC_RST_LED 8'h00

`endif
